// file: logic/aetf_defs.svh
// constants of the analog event transmit filter: widths, offsets, fields, reset values
`ifndef AETF_DEFS_SVH
`define AETF_DEFS_SVH

// ********************************************
// sizes
// ********************************************
`define CH_NUM 4
`define CH_W 2
`define VAL_W 16

// ********************************************
// threshold limits and defaults
// ********************************************
`define THR_MAX 16'h2710
`define LO_RST 16'h0000
`define HI_RST 16'h0000
`define DELTA_RST 16'h0032
`define LAST_RST 16'h0000

// ********************************************
// channel config word fields and reset
// ********************************************
`define CFG_LO_BIT 0
`define CFG_HI_BIT 1
`define CFG_DELTA_BIT 2
`define CFG_LO_RST 1'b0
`define CFG_HI_RST 1'b0
`define CFG_DELTA_RST 1'b1

// ********************************************
// register offsets: word index in a channel block, low address byte, or upper nibble of the last-value block
// ********************************************
`define OFS_CFG 2'h0
`define OFS_LO 2'h1
`define OFS_HI 2'h2
`define OFS_DELTA 2'h3
`define OFS_TXTYPE 8'h40
`define OFS_IRQ_STAT 8'h44
`define OFS_IRQ_MASK 8'h48
`define OFS_LAST_BASE 4'h5

// ********************************************
// transmission types and reset values of the globals
// ********************************************
`define TXTYPE_ACYC 8'h00
`define TXTYPE_ASYNC 8'hFF
`define TXTYPE_RST 8'hFF
`define IRQ_MASK_RST 4'h0

`endif

// file: logic/aetf_pkg.sv
// types shared by the analog event transmit filter modules
`include "aetf_defs.svh"

package aetf_pkg;

    // one signed sample or threshold
    typedef logic signed [`VAL_W-1:0] sample_t;

    // per-channel event settings
    typedef struct packed {
        logic lo_en;
        logic hi_en;
        logic delta_en;
        sample_t lo_thr;
        sample_t hi_thr;
        logic [`VAL_W-1:0] delta_thr;
    } chan_cfg_s;

    // bus slave phases
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_RD_WAIT,
        BUS_RD_DONE
    } bus_st_e;

endpackage

// file: logic/chan_cmp_if.sv
// carrier between the filter core and the condition evaluator
`timescale 1ns/1ps

interface chan_cmp_if;
    import aetf_pkg::*;
    aetf_pkg::sample_t value; // incoming sample
    aetf_pkg::sample_t last; // last transmitted value of that channel
    aetf_pkg::chan_cfg_s cfg; // settings of that channel
    logic met; // all enabled conditions hold
    logic any_en; // at least one condition enabled
    modport ctl (output value, output last, output cfg, input met, input any_en);
    modport eval (input value, input last, input cfg, output met, output any_en);
endinterface

// file: logic/chan_eval.sv
// combinational evaluation of the three event conditions of one sample
`timescale 1ns/1ps
`include "aetf_defs.svh"

module chan_eval (
    chan_cmp_if.eval cmp
);
    import aetf_pkg::*;

    // ********************************************
    // conditions
    // ********************************************
    logic signed [`VAL_W:0] diff; // one bit wider so no overflow
    logic [`VAL_W:0] mag; // absolute change
    logic lo_ok; // below lower threshold
    logic hi_ok; // above upper threshold
    logic delta_ok; // change beyond delta

    // signed compare and absolute difference
    always_comb begin
        diff = {cmp.value[`VAL_W-1], cmp.value} - {cmp.last[`VAL_W-1], cmp.last};
        mag = diff[`VAL_W] ? (~diff + 1'b1) : diff;
        lo_ok = cmp.value < cmp.cfg.lo_thr; // R1
        hi_ok = cmp.value > cmp.cfg.hi_thr; // R2
        delta_ok = mag > {1'b0, cmp.cfg.delta_thr}; // R3
    end

    // disabled conditions do not block; enabled ones must all hold
    assign cmp.met = (!cmp.cfg.lo_en || lo_ok) && (!cmp.cfg.hi_en || hi_ok)
        && (!cmp.cfg.delta_en || delta_ok); // R4 R5
    assign cmp.any_en = cmp.cfg.lo_en || cmp.cfg.hi_en || cmp.cfg.delta_en;

endmodule

// file: logic/analog_event_tx_filter.sv
// analog event transmit filter: per-channel event gating of samples toward the fieldbus
//
// Function
// (R1) lower condition met only below lower threshold
// (R2) upper condition met only above upper threshold
// (R3) delta met when change exceeds delta threshold
// (R4) each condition enabled separately per channel
// (R5) send only when all enabled conditions hold
// (R6) none enabled, type 0/255: never send
// (R7) defaults: limits off, delta on, 50
// (R8) separate event settings for every channel
// (R9) limit thresholds signed, clamped 0 to 10000
// (R10) delta threshold unsigned, clamped 0 to 10000
// (R11) sent value becomes next delta reference
`timescale 1ns/1ps
`include "aetf_defs.svh"

module analog_event_tx_filter (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic SAMPLE_VALID,
    output logic SAMPLE_READY,
    input wire logic [`CH_W-1:0] SAMPLE_CHAN,
    input wire aetf_pkg::sample_t SAMPLE_DATA,
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic [`CH_W-1:0] TX_CHAN,
    output aetf_pkg::sample_t TX_DATA,
    output logic IRQ
);
    import aetf_pkg::*;

    // ********************************************
    // declarations
    // ********************************************
    bus_st_e st_q; // bus slave phase
    bus_st_e st_d; // its next value
    logic [7:0] addr_q; // latched low address byte
    logic [31:0] rdata_q; // registered read data
    logic [31:0] rdata_d; // read mux output
    logic addr_ok; // valid address phase seen
    logic wr_now; // write data phase this cycle
    logic [`CH_W-1:0] wr_ch; // channel addressed by the write
    logic chan_area; // address lies in the channel block
    chan_cfg_s cfg_arr [`CH_NUM]; // settings of all channels
    sample_t last_arr [`CH_NUM]; // references of all channels
    logic [7:0] txtype_q; // process data transmission type
    logic [`CH_NUM-1:0] irq_stat_q; // sticky sent flags
    logic [`CH_NUM-1:0] irq_mask_q; // interrupt enables
    logic [`CH_NUM-1:0] sent_vec; // one-hot sent event this cycle
    logic tx_valid_q; // output slot full
    logic [`CH_W-1:0] tx_chan_q; // channel of pending value
    sample_t tx_data_q; // pending value
    logic acc; // a sample is taken this cycle
    logic acyclic; // type forbids untriggered sends
    logic send; // taken sample goes out
    chan_cmp_if cmp (); // evaluator carrier

    // clamp a limit threshold: negative goes to zero, large to the top
    function automatic sample_t clamp_lim(input logic [`VAL_W-1:0] w);
        sample_t r;
        if (w[`VAL_W-1]) begin
            r = '0;
        end else if (w > `THR_MAX) begin
            r = `THR_MAX;
        end else begin
            r = w;
        end
        return r;
    endfunction

    // clamp an unsigned delta threshold to the top of its range
    function automatic logic [`VAL_W-1:0] clamp_delta(input logic [`VAL_W-1:0] w);
        logic [`VAL_W-1:0] r;
        r = (w > `THR_MAX) ? `THR_MAX : w;
        return r;
    endfunction

    // ********************************************
    // ahb-lite slave
    // ********************************************
    // only NONSEQ/SEQ with hready high open a transfer
    assign addr_ok = HSEL && HTRANS[1] && HREADY;
    // reads take one wait state so a write just before is visible
    assign HREADYOUT = (st_q != BUS_RD_WAIT);
    // every answer is OKAY, unmapped ones included
    assign HRESP = 1'b0;
    assign HRDATA = rdata_q;
    assign wr_now = (st_q == BUS_WRITE);
    assign wr_ch = addr_q[5:4];
    assign chan_area = (addr_q[7:6] == 2'h0);

    // phase sequencing
    always_comb begin
        st_d = BUS_IDLE;
        if (HREADYOUT && addr_ok) begin
            st_d = HWRITE ? BUS_WRITE : BUS_RD_WAIT;
        end else if (st_q == BUS_RD_WAIT) begin
            st_d = BUS_RD_DONE;
        end
    end

    // phase register and address latch
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= BUS_IDLE;
            addr_q <= 8'h00;
        end else begin
            st_q <= st_d;
            if (HREADYOUT && addr_ok) begin
                addr_q <= HADDR[7:0];
            end
        end
    end

    // read mux; reserved and unmapped words read as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (chan_area) begin
            unique case (addr_q[3:2])
                `OFS_CFG: begin
                    rdata_d[`CFG_LO_BIT] = cfg_arr[wr_ch].lo_en;
                    rdata_d[`CFG_HI_BIT] = cfg_arr[wr_ch].hi_en;
                    rdata_d[`CFG_DELTA_BIT] = cfg_arr[wr_ch].delta_en;
                end
                `OFS_LO: rdata_d[`VAL_W-1:0] = cfg_arr[wr_ch].lo_thr;
                `OFS_HI: rdata_d[`VAL_W-1:0] = cfg_arr[wr_ch].hi_thr;
                `OFS_DELTA: rdata_d[`VAL_W-1:0] = cfg_arr[wr_ch].delta_thr;
            endcase
        end else if (addr_q == `OFS_TXTYPE) begin
            rdata_d[7:0] = txtype_q;
        end else if (addr_q == `OFS_IRQ_STAT) begin
            rdata_d[`CH_NUM-1:0] = irq_stat_q;
        end else if (addr_q == `OFS_IRQ_MASK) begin
            rdata_d[`CH_NUM-1:0] = irq_mask_q;
        end else if (addr_q[7:4] == `OFS_LAST_BASE) begin
            // last transmitted value, sign bits above stay zero
            rdata_d[`VAL_W-1:0] = last_arr[addr_q[3:2]];
        end
    end

    // read data captured in the wait cycle, held until the next read
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 32'h0000_0000;
        end else if (st_q == BUS_RD_WAIT) begin
            rdata_q <= rdata_d;
        end
    end

    // ********************************************
    // per-channel settings and reference
    // ********************************************
    genvar g;
    generate
        for (g = 0; g < `CH_NUM; g++) begin : g_ch
            chan_cfg_s cfg_q; // this channel's settings
            sample_t last_q; // this channel's delta reference
            logic hit; // write targets this channel

            assign hit = wr_now && chan_area && (wr_ch == `CH_W'(g));
            assign cfg_arr[g] = cfg_q; // R8
            assign last_arr[g] = last_q;

            // settings: defaults at reset, thresholds clamped on every write
            always_ff @(posedge REF_CLK or negedge RST_N) begin
                if (!RST_N) begin
                    cfg_q.lo_en <= `CFG_LO_RST; // R7
                    cfg_q.hi_en <= `CFG_HI_RST; // R7
                    cfg_q.delta_en <= `CFG_DELTA_RST; // R7
                    cfg_q.lo_thr <= `LO_RST;
                    cfg_q.hi_thr <= `HI_RST;
                    cfg_q.delta_thr <= `DELTA_RST; // R7
                end else if (hit) begin
                    unique case (addr_q[3:2])
                        `OFS_CFG: begin
                            // each enable is its own bit
                            cfg_q.lo_en <= HWDATA[`CFG_LO_BIT]; // R4
                            cfg_q.hi_en <= HWDATA[`CFG_HI_BIT]; // R4
                            cfg_q.delta_en <= HWDATA[`CFG_DELTA_BIT]; // R4
                        end
                        `OFS_LO: cfg_q.lo_thr <= clamp_lim(HWDATA[`VAL_W-1:0]); // R9
                        `OFS_HI: cfg_q.hi_thr <= clamp_lim(HWDATA[`VAL_W-1:0]); // R9
                        `OFS_DELTA: cfg_q.delta_thr <= clamp_delta(HWDATA[`VAL_W-1:0]); // R10
                    endcase
                end
            end

            // reference follows only values that really go out
            always_ff @(posedge REF_CLK or negedge RST_N) begin
                if (!RST_N) begin
                    last_q <= `LAST_RST;
                end else if (sent_vec[g]) begin
                    last_q <= SAMPLE_DATA; // R11
                end
            end
        end
    endgenerate

    // ********************************************
    // global registers
    // ********************************************
    // transmission type, read by the gate below
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            txtype_q <= `TXTYPE_RST;
        end else if (wr_now && addr_q == `OFS_TXTYPE) begin
            txtype_q <= HWDATA[7:0];
        end
    end

    // interrupt mask
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_mask_q <= `IRQ_MASK_RST;
        end else if (wr_now && addr_q == `OFS_IRQ_MASK) begin
            irq_mask_q <= HWDATA[`CH_NUM-1:0];
        end
    end

    // sticky sent flags; a new event beats a clear in the same cycle
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat_q <= '0;
        end else if (wr_now && addr_q == `OFS_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~HWDATA[`CH_NUM-1:0]) | sent_vec;
        end else begin
            irq_stat_q <= irq_stat_q | sent_vec;
        end
    end

    // level interrupt from unmasked flags
    assign IRQ = |(irq_stat_q & irq_mask_q);

    // ********************************************
    // event gate
    // ********************************************
    chan_eval u_eval (
        .cmp(cmp)
    );

    assign cmp.value = SAMPLE_DATA;
    assign cmp.last = last_arr[SAMPLE_CHAN];
    assign cmp.cfg = cfg_arr[SAMPLE_CHAN];

    // one slot: refills in the cycle it drains, so no bubble
    assign SAMPLE_READY = !tx_valid_q || TX_READY;
    assign acc = SAMPLE_VALID && SAMPLE_READY;
    assign acyclic = (txtype_q == `TXTYPE_ACYC) || (txtype_q == `TXTYPE_ASYNC);
    // with nothing enabled, only cyclic types still pass samples
    assign send = cmp.any_en ? cmp.met : !acyclic; // R5 R6
    assign sent_vec = (acc && send) ? (`CH_NUM'(1) << SAMPLE_CHAN) : '0;

    // output slot held until the master takes it
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_valid_q <= 1'b0;
            tx_chan_q <= '0;
            tx_data_q <= '0;
        end else if (acc) begin
            tx_valid_q <= send; // R5 R6
            if (send) begin
                tx_chan_q <= SAMPLE_CHAN;
                tx_data_q <= SAMPLE_DATA;
            end
        end else if (TX_READY) begin
            tx_valid_q <= 1'b0;
        end
    end

    assign TX_VALID = tx_valid_q;
    assign TX_CHAN = tx_chan_q;
    assign TX_DATA = tx_data_q;

    // ********************************************
    // assertions
    // ********************************************
    a_reset_defaults: assert property (@(posedge REF_CLK) // R7
        $rose(RST_N) |-> cfg_arr[0].delta_en && !cfg_arr[0].lo_en && !cfg_arr[0].hi_en
        && cfg_arr[0].delta_thr == 16'h0032 && cfg_arr[3].delta_thr == 16'h0032)
        else $error("channel defaults wrong after reset");

    a_limit_range: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R9
        cfg_arr[1].lo_thr >= 0 && cfg_arr[1].lo_thr <= 16'sd10000
        && cfg_arr[1].hi_thr >= 0 && cfg_arr[1].hi_thr <= 16'sd10000)
        else $error("limit threshold out of range");

    a_delta_range: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R10
        wr_now && chan_area && addr_q[3:2] == 2'h3 |=>
        cfg_arr[$past(wr_ch)].delta_thr <= 16'd10000)
        else $error("delta threshold out of range");

    a_enable_bits: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R4
        wr_now && chan_area && addr_q[3:2] == 2'h0 |=>
        {cfg_arr[$past(wr_ch)].delta_en, cfg_arr[$past(wr_ch)].hi_en,
        cfg_arr[$past(wr_ch)].lo_en} == $past(HWDATA[2:0]))
        else $error("enable bits not written as given");

    a_lower_gate: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R1
        acc && cmp.cfg.lo_en && !(SAMPLE_DATA < cmp.cfg.lo_thr) |=> !tx_valid_q)
        else $error("sent although not below lower threshold");

    a_upper_gate: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R2
        acc && cmp.cfg.hi_en && !(SAMPLE_DATA > cmp.cfg.hi_thr) |=> !tx_valid_q)
        else $error("sent although not above upper threshold");

    a_silent_acyc: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R6
        acc && !cmp.any_en && acyclic |=> !tx_valid_q ##1 !tx_valid_q || $past(acc))
        else $error("sent with no condition in acyclic mode");

    a_send_value: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R5
        acc && cmp.any_en && cmp.met |=> tx_valid_q && tx_data_q == $past(SAMPLE_DATA)
        && tx_chan_q == $past(SAMPLE_CHAN))
        else $error("met sample not presented");

    a_ref_update: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R11
        acc && send |=> last_arr[tx_chan_q] == tx_data_q && irq_stat_q[tx_chan_q])
        else $error("reference or flag not updated on send");

    a_tx_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        tx_valid_q && !TX_READY |=> tx_valid_q && $stable(tx_data_q) && !$past(SAMPLE_READY))
        else $error("pending value lost under back-pressure");

endmodule

// file: sim/fieldbus_sink.sv
// fieldbus master model: takes pending transmit values promptly or slowly
`timescale 1ns/1ps
`include "aetf_defs.svh"

module fieldbus_sink (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [`CH_W-1:0] tx_chan,
    input wire aetf_pkg::sample_t tx_data,
    output logic tx_ready,
    output logic [15:0] rx_count,
    output logic [`CH_W-1:0] rx_chan,
    output aetf_pkg::sample_t rx_data
);
    import aetf_pkg::*;

    // ********************************************
    // ready pacing
    // ********************************************
    logic [1:0] ph_q; // phase of the slow pattern

    // slow mode takes one value in three cycles, so the slot backs up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
            tx_ready <= !slow || (ph_q == 2'h1);
        end
    end

    // ********************************************
    // capture of delivered values
    // ********************************************
    // only the last value is kept; the bench checks counts and the newest one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_count <= 16'h0000;
            rx_chan <= '0;
            rx_data <= '0;
        end else if (tx_valid && tx_ready) begin
            rx_count <= rx_count + 16'h0001;
            rx_chan <= tx_chan;
            rx_data <= tx_data;
        end
    end
endmodule

// file: sim/testbench.sv
// self-checking bench of the analog event transmit filter
`timescale 1ns/1ps
`include "aetf_defs.svh"

module testbench;
    import aetf_pkg::*;

    // ********************************************
    // signals
    // ********************************************
    logic REF_CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, IRQ, slow;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic SAMPLE_VALID, SAMPLE_READY, TX_VALID, TX_READY;
    logic [`CH_W-1:0] SAMPLE_CHAN, TX_CHAN, rx_chan;
    sample_t SAMPLE_DATA, TX_DATA, rx_data;
    logic [15:0] rx_count, base; // base: count after last drained sample
    logic hready; // single slave: its ready is the bus ready
    int n_mismatch, n_compared;
    assign hready = HREADYOUT;

    analog_event_tx_filter dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(hready),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SAMPLE_VALID(SAMPLE_VALID),
        .SAMPLE_READY(SAMPLE_READY), .SAMPLE_CHAN(SAMPLE_CHAN), .SAMPLE_DATA(SAMPLE_DATA),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_CHAN(TX_CHAN), .TX_DATA(TX_DATA),
        .IRQ(IRQ));

    fieldbus_sink sink (.clk(REF_CLK), .rst_n(RST_N), .slow(slow), .tx_valid(TX_VALID),
        .tx_chan(TX_CHAN), .tx_data(TX_DATA), .tx_ready(TX_READY), .rx_count(rx_count),
        .rx_chan(rx_chan), .rx_data(rx_data));

    // clock of 20 ns
    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end

    // ********************************************
    // tasks
    // ********************************************
    task automatic give_verdict();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // byte address of a channel register
    function automatic logic [7:0] ra(input logic [1:0] ch, input logic [1:0] ofs);
        return {2'b00, ch, ofs, 2'b00};
    endfunction

    // one write: address phase, then data phase, each until ready
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HADDR <= {24'h000000, a};
        HTRANS <= 2'h2;
        HWRITE <= 1'b1;
        @(posedge REF_CLK);
        while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge REF_CLK);
        while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
    endtask

    // one read; data taken at the edge where ready is seen in the data phase
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        HSEL <= 1'b1;
        HADDR <= {24'h000000, a};
        HTRANS <= 2'h2;
        HWRITE <= 1'b0;
        @(posedge REF_CLK);
        while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
        HTRANS <= 2'h0;
        @(posedge REF_CLK);
        while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
        check(HRDATA, exp);
        check({31'h0, HRESP}, 32'h0);
    endtask

    // offer one sample; when draining, check how many values reached the master
    task automatic put(input logic [1:0] ch, input logic [15:0] d, input logic [1:0] nexp,
                       input logic drain);
        SAMPLE_VALID <= 1'b1;
        SAMPLE_CHAN <= ch;
        SAMPLE_DATA <= d;
        @(posedge REF_CLK);
        while (SAMPLE_READY !== 1'b1) @(posedge REF_CLK);
        // without drain the next call follows at once, so valid stays up
        if (drain) begin
            SAMPLE_VALID <= 1'b0;
            repeat (2) @(posedge REF_CLK);
            while (TX_VALID !== 1'b0) @(posedge REF_CLK);
            check(32'(rx_count - base), 32'(nexp));
            if (nexp != 2'h0) check({14'h0, rx_chan, rx_data}, {14'h0, ch, d});
            base = rx_count;
        end
    endtask

    // ********************************************
    // watchdog
    // ********************************************
    // whole run needs a few hundred cycles; this margin is generous
    initial begin
        repeat (20000) @(posedge REF_CLK);
        n_mismatch++;
        give_verdict();
    end

    // ********************************************
    // main sequence
    // ********************************************
    initial begin
        {RST_N, HSEL, HWRITE, SAMPLE_VALID, slow} = 5'h00;
        {HADDR, HWDATA, HTRANS, HSIZE} = {64'h0, 2'h0, 3'h2};
        {SAMPLE_CHAN, SAMPLE_DATA, base, n_mismatch, n_compared} = '0;
        repeat (20) @(posedge REF_CLK);
        RST_N <= 1'b1;
        @(posedge REF_CLK);
        // defaults of every channel
        for (int c = 0; c < 4; c++) begin
            rd_chk(ra(2'(c), `OFS_CFG), 32'h4);
            rd_chk(ra(2'(c), `OFS_DELTA), 32'h32);
            rd_chk(ra(2'(c), `OFS_LO), 32'h0);
            rd_chk({`OFS_LAST_BASE, 2'(c), 2'b00}, 32'h0);
        end
        rd_chk(`OFS_TXTYPE, 32'hFF);
        rd_chk(8'h7C, 32'h0); // unmapped
        // default delta of 50, both directions
        put(2'h0, 16'h0032, 2'h0, 1'b1);
        put(2'h0, 16'h0033, 2'h1, 1'b1);
        put(2'h0, 16'h0064, 2'h0, 1'b1);
        put(2'h0, 16'h0066, 2'h1, 1'b1);
        put(2'h0, 16'h0033, 2'h1, 1'b1);
        rd_chk({`OFS_LAST_BASE, 2'h0, 2'b00}, 32'h33);
        // threshold limits
        bus_wr(ra(2'h3, `OFS_LO), 32'h0000FFF0);
        rd_chk(ra(2'h3, `OFS_LO), 32'h0);
        bus_wr(ra(2'h3, `OFS_HI), 32'hABCD2711);
        rd_chk(ra(2'h3, `OFS_HI), 32'h2710);
        bus_wr(ra(2'h3, `OFS_DELTA), 32'h0000FFFF);
        rd_chk(ra(2'h3, `OFS_DELTA), 32'h2710);
        // lower limit only, signed compare
        bus_wr(ra(2'h1, `OFS_CFG), 32'h1);
        bus_wr(ra(2'h1, `OFS_LO), 32'h3E8);
        put(2'h1, 16'h03E7, 2'h1, 1'b1);
        put(2'h1, 16'h03E8, 2'h0, 1'b1);
        put(2'h1, 16'hFFFB, 2'h1, 1'b1);
        // upper limit only
        bus_wr(ra(2'h2, `OFS_CFG), 32'h2);
        bus_wr(ra(2'h2, `OFS_HI), 32'h1388);
        put(2'h2, 16'h1388, 2'h0, 1'b1);
        put(2'h2, 16'h1389, 2'h1, 1'b1);
        // upper and delta together, then all three
        bus_wr(ra(2'h3, `OFS_CFG), 32'h6);
        bus_wr(ra(2'h3, `OFS_HI), 32'h1388);
        bus_wr(ra(2'h3, `OFS_DELTA), 32'h64);
        put(2'h3, 16'h1770, 2'h1, 1'b1);
        put(2'h3, 16'h17A2, 2'h0, 1'b1);
        put(2'h3, 16'h0FA0, 2'h0, 1'b1);
        put(2'h3, 16'h17D5, 2'h1, 1'b1);
        bus_wr(ra(2'h3, `OFS_CFG), 32'h7);
        bus_wr(ra(2'h3, `OFS_LO), 32'h1F40);
        put(2'h3, 16'h1B58, 2'h1, 1'b1);
        put(2'h3, 16'h2134, 2'h0, 1'b1);
        // other channels left untouched
        rd_chk(ra(2'h0, `OFS_CFG), 32'h4);
        put(2'h0, 16'h00C8, 2'h1, 1'b1);
        // no condition enabled: types 0xFF and 0x00 never send, a cyclic type does
        bus_wr(ra(2'h1, `OFS_CFG), 32'h0);
        put(2'h1, 16'h0BB8, 2'h0, 1'b1);
        bus_wr(`OFS_TXTYPE, 32'h0);
        put(2'h1, 16'h0BB8, 2'h0, 1'b1);
        bus_wr(`OFS_TXTYPE, 32'h1);
        put(2'h1, 16'h0BB8, 2'h1, 1'b1);
        rd_chk({`OFS_LAST_BASE, 2'h1, 2'b00}, 32'hBB8);
        // interrupt: raise, mask, clear
        rd_chk(`OFS_IRQ_STAT, 32'hF);
        check({31'h0, IRQ}, 32'h0);
        bus_wr(`OFS_IRQ_MASK, 32'h2);
        @(posedge REF_CLK);
        check({31'h0, IRQ}, 32'h1);
        bus_wr(`OFS_IRQ_STAT, 32'h2);
        @(posedge REF_CLK);
        check({31'h0, IRQ}, 32'h0);
        rd_chk(`OFS_IRQ_STAT, 32'hD);
        // slow master: second sample waits for the slot, both delivered in order
        slow <= 1'b1;
        put(2'h2, 16'h1770, 2'h0, 1'b0);
        put(2'h2, 16'h1B58, 2'h2, 1'b1);
        check({31'h0, IRQ}, 32'h0);
        bus_wr(`OFS_IRQ_MASK, 32'h4);
        @(posedge REF_CLK);
        check({31'h0, IRQ}, 32'h1);
        give_verdict();
    end
endmodule
